// ==== bench/serial_rx_model.sv ====
// behavioural receiver that decodes each frame on the line
`timescale 1ns/100ps
`default_nettype none

module serial_rx_model (
    // clock and line
    input  wire logic  ref_clk_in,
    input  wire logic  serial_in,
    input  wire logic  data_clk_in,
    input  wire logic  par_en_in,
    // decoded frame
    output logic [7:0] byte_out,
    output logic       par_out,
    output logic       stop_out,
    output int         frames_out,
    output logic [7:0] dclk_byte_out
);
    initial frames_out = 0;
    // bits taken on the data clock rise, as a checking unit would
    always @(posedge data_clk_in) dclk_byte_out <= {serial_in, dclk_byte_out[7:1]};
    always begin
        @(negedge serial_in);
        repeat (4) @(posedge ref_clk_in);
        if (serial_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (8) @(posedge ref_clk_in);
                byte_out[i] = serial_in;
            end
            if (par_en_in) begin
                repeat (8) @(posedge ref_clk_in);
                par_out = serial_in;
            end
            repeat (8) @(posedge ref_clk_in);
            stop_out = serial_in;
            frames_out++;
        end
    end
endmodule
`default_nettype wire

// ==== bench/uart_tx_parity_dataclk_bench.sv ====
// self-checking bench for the serial transmitter
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_defines.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end

module uart_tx_parity_dataclk_bench;
    logic        ref_clk_in, rst_in, hsel_in, hwrite_in, par_en;
    logic [7:0]  haddr_in, rx_byte, dclk_byte, b;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic [31:0] hwdata_in, hrdata_out, x;
    logic        hreadyout_out, hresp_out, serial_out, data_clk_out, irq_out, rx_par, stop_bit;
    logic [7:0]  codes [3];
    int          rx_frames, error_cnt, comparisons, seed, n;

    uart_tx_parity_dataclk u_dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hreadyout_out),
        .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .serial_out(serial_out), .data_clk_out(data_clk_out), .irq_out(irq_out)
    );
    serial_rx_model u_rx (
        .ref_clk_in(ref_clk_in), .serial_in(serial_out), .data_clk_in(data_clk_out), .par_en_in(par_en),
        .byte_out(rx_byte), .par_out(rx_par), .stop_out(stop_bit), .frames_out(rx_frames),
        .dclk_byte_out(dclk_byte)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    function automatic logic exp_par(input logic [7:0] d, input logic [7:0] c);
        return c[2] ? ~^d : ^d;
    endfunction

    task automatic final_report;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic give_up;
        error_cnt++;
        final_report();
    endtask

    // one single transfer; called just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        int k;
        k = 0;
        haddr_in <= a;
        htrans_in <= 2'h2;
        hwrite_in <= w;
        do begin @(posedge ref_clk_in); k++; end while (hreadyout_out !== 1'b1 && k < 40);
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        do begin @(posedge ref_clk_in); k++; end while (hreadyout_out !== 1'b1 && k < 40);
        rd = hrdata_out;
        if (k >= 40) give_up();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(a, 1'b0, 32'h0, r);
        `CHK("register", e, r)
    endtask

    task automatic collect(input logic [7:0] d, input logic [7:0] c);
        int k, f;
        k = 0;
        f = rx_frames;
        while (rx_frames == f && k < 300) begin
            @(posedge ref_clk_in);
            k++;
        end
        if (k >= 300) give_up();
        `CHK("byte", d, rx_byte)
        `CHK("dclk byte", d, dclk_byte)
        `CHK("stop", 1'b1, stop_bit)
        if (c != 8'h00) `CHK("parity", exp_par(d, c), rx_par)
    endtask

    // start must follow the write within eleven clocks
    task automatic send(input logic [7:0] d, input logic [7:0] c);
        int k;
        k = 0;
        wr(`OFF_DATA, {24'h0, d});
        while (serial_out !== 1'b0 && k < 11) begin
            @(posedge ref_clk_in);
            k++;
        end
        `CHK("start", 1'b1, k < 11)
        if (d != 8'h00) collect(d, c);
    endtask

    initial begin
        rst_in = 1'b1;
        {hsel_in, hwrite_in, haddr_in, htrans_in, hwdata_in, par_en} = '0;
        hsize_in = 3'h2;
        error_cnt = 0;
        comparisons = 0;
        codes = '{`PARITY_OFF_CODE, `PARITY_EVEN_CODE, `PARITY_ODD_CODE};
        seed = $urandom(39606);
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        hsel_in <= 1'b1;
        @(posedge ref_clk_in);
        `CHK("idle", 3'b110, {serial_out, data_clk_out, irq_out})
        rd_chk(`OFF_STATUS, 32'h10);
        rd_chk(8'h1C, 32'h0);
        wr(`OFF_IRQ_ENABLE, 32'h1);
        wr(`OFF_IRQ_MODE, {24'h0, `IRQ_ON_BUFFER_EMPTY});
        for (int i = 0; i < 3; i++) begin
            wr(`OFF_CTRL, {24'h0, codes[i] | 8'h01});
            par_en = codes[i][1];
            send(8'hA5 ^ 8'(i), codes[i]);
        end
        // receiver reports at mid stop bit; frame-done comes at its end
        repeat (8) @(posedge ref_clk_in);
        `CHK("irq", 1'b1, irq_out)
        rd_chk(`OFF_IRQ_STATUS, 32'h3);
        rd_chk(`OFF_STATUS, 32'h30);
        rd_chk(`OFF_STATUS, 32'h0);
        wr(`OFF_IRQ_ENABLE, 32'h0);
        repeat (2) @(posedge ref_clk_in);
        `CHK("irq masked", 1'b0, irq_out)
        wr(`OFF_IRQ_ENABLE, 32'h1);
        repeat (2) @(posedge ref_clk_in);
        `CHK("irq pending", 1'b1, irq_out)
        wr(`OFF_IRQ_CLEAR, 32'h3);
        rd_chk(`OFF_IRQ_STATUS, 32'h0);
        `CHK("irq cleared", 1'b0, irq_out)
        wr(`OFF_IRQ_MODE, {24'h0, `IRQ_ON_FRAME_DONE});
        wr(`OFF_IRQ_ENABLE, 32'h3);
        send(8'h00, codes[2]);
        `CHK("irq at load", 1'b0, irq_out)
        collect(8'h00, codes[2]);
        for (n = 0; n < 12 && irq_out !== 1'b1; n++) @(posedge ref_clk_in);
        `CHK("irq frame done", 1'b1, irq_out)
        wr(`OFF_IRQ_CLEAR, 32'h3);
        wr(`OFF_DATA, 32'h3C);
        x = 32'h0;
        for (n = 0; n < 20 && x[`BUFFER_EMPTY_BIT] !== 1'b1; n++) bus(`OFF_STATUS, 1'b0, 32'h0, x);
        `CHK("empty at load", 1'b1, x[`BUFFER_EMPTY_BIT])
        wr(`OFF_DATA, 32'hC3);
        collect(8'h3C, codes[2]);
        collect(8'hC3, codes[2]);
        send(8'h00, codes[2]);
        wr(`OFF_CTRL, 32'h0);
        repeat (3) @(posedge ref_clk_in);
        `CHK("disabled", 2'b11, {serial_out, data_clk_out})
        repeat (120) @(posedge ref_clk_in);
        for (int i = 0; i < 6; i++) begin
            x[7:0] = codes[$urandom % 3];
            b = 8'($urandom) | 8'h01;
            wr(`OFF_CTRL, {24'h0, x[7:0] | 8'h01});
            par_en = x[1];
            send(b, x[7:0]);
        end
        final_report();
    end
endmodule
`default_nettype wire

// ==== bench/uart_tx_parity_dataclk_chk.sv ====
// port checker for the serial transmitter
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_defines.svh"

module uart_tx_chk (
    // clock, reset and bus
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic        hsel_in,
    input wire logic [7:0]  haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hwdata_in,
    // outputs
    input wire logic        hresp_out,
    input wire logic        serial_out,
    input wire logic        data_clk_out,
    input wire logic        irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    logic       wr_reg;
    logic [7:0] wa_reg;
    logic       en_reg;
    logic [1:0] ie_reg;
    // shadow of enable and mask, rebuilt from bus writes
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_reg <= 1'b0;
            wa_reg <= 8'h00;
            en_reg <= 1'b0;
            ie_reg <= 2'h0;
        end else if (hready_in) begin
            wr_reg <= hsel_in && htrans_in[1] && hwrite_in;
            wa_reg <= haddr_in;
            if (wr_reg && wa_reg == `OFF_CTRL) en_reg <= hwdata_in[0];
            if (wr_reg && wa_reg == `OFF_IRQ_ENABLE) ie_reg <= hwdata_in[1:0];
        end
    end
    dclk_period_a: assert property ($fell(data_clk_out) |-> !data_clk_out [*4] ##1 data_clk_out [*4])
        else $error("data clock half period wrong");
    dclk_sample_a: assert property ($rose(data_clk_out) |-> $stable(serial_out) [*4])
        else $error("line moved near data clock rise");
    dclk_quiet_a: assert property ($fell(serial_out) && data_clk_out && $past(data_clk_out) |-> data_clk_out [*8])
        else $error("data clock moved outside data bits");
    bit_len_a: assert property ($changed(serial_out) |-> ##1 (!en_reg || $stable(serial_out)) [*7])
        else $error("bit shorter than eight clocks");
    idle_off_a: assert property (!en_reg && !$past(en_reg) |=> serial_out && data_clk_out)
        else $error("line active while disabled");
    dclk_off_a: assert property ($fell(data_clk_out) |-> $past(en_reg))
        else $error("data clock while disabled");
    irq_mask_a: assert property (irq_out |-> $past(ie_reg) != 2'h0 || $past(ie_reg, 2) != 2'h0)
        else $error("interrupt with mask clear");
    bus_okay_a: assert property (!hresp_out)
        else $error("bus response not okay");
    cover property ($fell(data_clk_out));
    cover property ($rose(irq_out));
    cover property ($fell(en_reg) && !serial_out);
endmodule

bind uart_tx_parity_dataclk uart_tx_chk u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in), .hwdata_in(hwdata_in),
    .hresp_out(hresp_out), .serial_out(serial_out), .data_clk_out(data_clk_out), .irq_out(irq_out)
);
`default_nettype wire

// ==== shared/uart_tx_defines.svh ====
// offsets, field positions, reset values and timing counts of the serial transmitter
`ifndef UART_TX_DEFINES_SVH
`define UART_TX_DEFINES_SVH

`define CLK_HZ              10000000
`define BIT_DIV             8
`define BIT_DIV_W           3

`define OFF_CTRL            8'h00
`define OFF_DATA            8'h04
`define OFF_STATUS          8'h08
`define OFF_IRQ_MODE        8'h0C
`define OFF_IRQ_ENABLE      8'h10
`define OFF_IRQ_STATUS      8'h14
`define OFF_IRQ_CLEAR       8'h18

`define CTRL_ENABLE_BIT     0
`define CTRL_PARITY_LSB     1
`define CTRL_PARITY_MSB     2
`define CTRL_RESET          8'h00

`define PARITY_OFF_CODE     8'h00
`define PARITY_EVEN_CODE    8'h02
`define PARITY_ODD_CODE     8'h06

`define IRQ_ON_BUFFER_EMPTY 8'h00
`define IRQ_ON_FRAME_DONE   8'h01

`define FRAME_DONE_BIT      5
`define BUFFER_EMPTY_BIT    4

`define IRQ_BIT_BUFFER      0
`define IRQ_BIT_FRAME       1

`endif

// ==== shared/uart_tx_pkg.sv ====
// types of the serial transmitter
package uart_tx_pkg;
    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_PARITY,
        TX_STOP
    } tx_state_t;
endpackage

// ==== verilog/bit_tick.sv ====
// bit clock divider: one-cycle tick every eight input clocks while enabled
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_defines.svh"

module bit_tick (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // control
    input  wire logic run_in,
    output logic      tick_out,
    output logic [`BIT_DIV_W-1:0] phase_out
);
    logic [`BIT_DIV_W-1:0] count_reg;

    // divider restarts on disable so the first tick is a full bit after enable
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else if (!run_in) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_reg + 1'b1;
        end
    end

    assign tick_out  = run_in && (count_reg == `BIT_DIV_W'(`BIT_DIV - 1));
    assign phase_out = count_reg;
endmodule
`default_nettype wire

// ==== verilog/uart_tx_parity_dataclk.sv ====
// AHB-Lite serial transmitter with parity, interrupt steering and data clock output
// Operation
// - data clock output runs at input clock divided by eight, one period per bit
// - data clock toggles only during the eight data bits, else held high
// - data clock rises while the data bit on the line is stable
// - when enabled, transmission starts on next bit clock after buffer write, or at the end of the stop bit of a frame in progress
// - clearing enable stops bit clock and any further transmission
// - parity code 0x00 none, 0x02 even, 0x06 odd, written with enable
// - transmit interrupt forwarded only while its mask bit is set
// - setting mask with pending condition raises interrupt at once
// - software-writable selection picks which event drives the interrupt
// - frame is start, eight data bits lsb first, optional parity, one stop
// - buffer-empty flag comes on the edge that loads shifter, start bit one clock later
// - selection 0x00 buffer-empty at load, 0x01 frame-done after last bit
// - status holds frame-done at 0x20 and buffer-empty at 0x10, cleared on read
`timescale 1ns/100ps
`default_nettype none
`include "uart_tx_defines.svh"

module uart_tx_parity_dataclk (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [7:0]  haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hwdata_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // serial side
    output logic             serial_out,
    output logic             data_clk_out,
    // interrupt
    output logic             irq_out
);
    uart_tx_pkg::tx_state_t state_reg;

    logic [7:0] ctrl_reg;
    logic [7:0] irq_mode_reg;
    logic [1:0] irq_enable_reg;
    logic [1:0] irq_status_reg;
    logic [7:0] buffer_reg;
    logic       buffer_full_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_count_reg;
    logic       parity_reg;
    logic       buffer_empty_flag_reg;
    logic       frame_done_flag_reg;

    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic [7:0]  addr_reg;

    logic        tick;
    logic [2:0]  phase;
    logic        enabled;
    logic        parity_on;
    logic        parity_odd;
    logic        load_now;
    logic        done_now;
    logic        buffer_empty_event;
    logic        frame_done_event;
    logic        status_read;
    logic        data_write;
    logic        clear_write;
    logic        addr_phase;
    logic [31:0] rd_word;

    assign enabled    = ctrl_reg[`CTRL_ENABLE_BIT];
    assign parity_on  = ctrl_reg[`CTRL_PARITY_LSB];
    assign parity_odd = ctrl_reg[`CTRL_PARITY_MSB];

    bit_tick u_bit_tick (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .run_in     (enabled),
        .tick_out   (tick),
        .phase_out  (phase)
    );

    // bus: single-cycle data phase, every access is OKAY
    assign addr_phase  = hsel_in && hready_in && htrans_in[1];
    assign data_write  = wr_pend_reg && (addr_reg == `OFF_DATA);
    assign clear_write = wr_pend_reg && (addr_reg == `OFF_IRQ_CLEAR);
    assign status_read = addr_phase && !hwrite_in && (haddr_in == `OFF_STATUS);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite_in;
            rd_pend_reg <= addr_phase && !hwrite_in;
            addr_reg    <= haddr_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg       <= `CTRL_RESET;
            irq_mode_reg   <= `IRQ_ON_BUFFER_EMPTY;
            irq_enable_reg <= 2'h0;
        end else if (wr_pend_reg) begin
            unique case (addr_reg)
                `OFF_CTRL:       ctrl_reg       <= hwdata_in[7:0];
                `OFF_IRQ_MODE:   irq_mode_reg   <= hwdata_in[7:0];
                `OFF_IRQ_ENABLE: irq_enable_reg <= hwdata_in[1:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (haddr_in)
            `OFF_CTRL:       rd_word[7:0] = ctrl_reg;
            `OFF_STATUS: begin
                rd_word[`FRAME_DONE_BIT]   = frame_done_flag_reg;
                rd_word[`BUFFER_EMPTY_BIT] = buffer_empty_flag_reg;
            end
            `OFF_IRQ_MODE:   rd_word[7:0] = irq_mode_reg;
            `OFF_IRQ_ENABLE: rd_word[1:0] = irq_enable_reg;
            `OFF_IRQ_STATUS: rd_word[1:0] = irq_status_reg;
            default:         rd_word      = 32'h0000_0000;
        endcase
    end

    // read data registered at the address phase so hrdata comes from a flop
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_phase && !hwrite_in) begin
            hrdata_out <= rd_word;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // transmit buffer
    assign load_now = tick && buffer_full_reg && (state_reg == uart_tx_pkg::TX_IDLE
                      || (state_reg == uart_tx_pkg::TX_STOP));
    assign done_now = tick && (state_reg == uart_tx_pkg::TX_STOP);
    assign buffer_empty_event = load_now;
    assign frame_done_event   = done_now;

    // an overwrite before the load simply replaces the pending byte
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            buffer_reg      <= 8'h00;
            buffer_full_reg <= 1'b0;
        end else if (data_write) begin
            buffer_reg      <= hwdata_in[7:0];
            buffer_full_reg <= 1'b1;
        end else if (load_now || !enabled) begin
            buffer_full_reg <= buffer_full_reg && enabled && !load_now;
        end
    end

    // frame sequencer, one step per bit tick
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg     <= uart_tx_pkg::TX_IDLE;
            shift_reg     <= 8'h00;
            bit_count_reg <= 3'h0;
            parity_reg    <= 1'b0;
        end else if (!enabled) begin
            state_reg <= uart_tx_pkg::TX_IDLE;
        end else if (tick) begin
            unique case (state_reg)
                uart_tx_pkg::TX_IDLE: begin
                    if (load_now) begin
                        state_reg  <= uart_tx_pkg::TX_START;
                        shift_reg  <= buffer_reg;
                        parity_reg <= parity_odd;
                    end
                end
                uart_tx_pkg::TX_START: begin
                    state_reg     <= uart_tx_pkg::TX_DATA;
                    bit_count_reg <= 3'h0;
                end
                uart_tx_pkg::TX_DATA: begin
                    parity_reg    <= parity_reg ^ shift_reg[0];
                    shift_reg     <= {1'b0, shift_reg[7:1]};
                    bit_count_reg <= bit_count_reg + 3'h1;
                    if (bit_count_reg == 3'h7) begin
                        state_reg <= parity_on ? uart_tx_pkg::TX_PARITY : uart_tx_pkg::TX_STOP;
                    end
                end
                uart_tx_pkg::TX_PARITY: state_reg <= uart_tx_pkg::TX_STOP;
                uart_tx_pkg::TX_STOP: begin
                    // back-to-back frame: next start bit follows the stop bit directly
                    if (load_now) begin
                        state_reg  <= uart_tx_pkg::TX_START;
                        shift_reg  <= buffer_reg;
                        parity_reg <= parity_odd;
                    end else begin
                        state_reg <= uart_tx_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    // serial line and data clock; data clock low for first half of each data bit
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_out   <= 1'b1;
            data_clk_out <= 1'b1;
        end else begin
            unique case (state_reg)
                uart_tx_pkg::TX_IDLE:   serial_out <= 1'b1;
                uart_tx_pkg::TX_START:  serial_out <= 1'b0;
                uart_tx_pkg::TX_DATA:   serial_out <= shift_reg[0];
                uart_tx_pkg::TX_PARITY: serial_out <= parity_reg;
                uart_tx_pkg::TX_STOP:   serial_out <= 1'b1;
            endcase
            // rises mid-bit, four clocks after the bit settled
            data_clk_out <= !((state_reg == uart_tx_pkg::TX_DATA) && !phase[2]);
        end
    end

    // status flags: set wins over the clear-on-read
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            buffer_empty_flag_reg <= 1'b1;
            frame_done_flag_reg   <= 1'b0;
        end else begin
            if (data_write) begin
                buffer_empty_flag_reg <= 1'b0;
            end else if (buffer_empty_event) begin
                buffer_empty_flag_reg <= 1'b1;
            end else if (status_read) begin
                buffer_empty_flag_reg <= 1'b0;
            end
            if (frame_done_event) begin
                frame_done_flag_reg <= 1'b1;
            end else if (status_read) begin
                frame_done_flag_reg <= 1'b0;
            end
        end
    end

    // sticky interrupt causes; the mode picks which one reaches the pin
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_status_reg <= 2'h0;
        end else begin
            irq_status_reg[`IRQ_BIT_BUFFER] <= buffer_empty_event
                || (irq_status_reg[`IRQ_BIT_BUFFER] && !(clear_write && hwdata_in[`IRQ_BIT_BUFFER]));
            irq_status_reg[`IRQ_BIT_FRAME]  <= frame_done_event
                || (irq_status_reg[`IRQ_BIT_FRAME] && !(clear_write && hwdata_in[`IRQ_BIT_FRAME]));
        end
    end

    // combinational mask path would be faster, but the output must be a flop
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else if (irq_mode_reg == `IRQ_ON_FRAME_DONE) begin
            irq_out <= irq_status_reg[`IRQ_BIT_FRAME] && irq_enable_reg[`IRQ_BIT_FRAME];
        end else begin
            irq_out <= irq_status_reg[`IRQ_BIT_BUFFER] && irq_enable_reg[`IRQ_BIT_BUFFER];
        end
    end
endmodule
`default_nettype wire
